// [core/sfp_fifo_top.sv]
// nine-bit fifo with empty, full and programmable almost flags
// Operation
// - nine-bit word in, nine-bit word out
// - two-enable write: a low, b high, not full
// - load config: gate a alone enables data writes
// - pin high at clear: second write enable
// - pin low at clear: threshold load control
// - writes while full are ignored entirely
// - load asserted: write edge loads a threshold
// - load asserted: read edge outputs a threshold
// - read needs both read gates low, not empty
// - empty flag low when no words, read side
// - full flag low at capacity, write side
// - almost empty low at count <= threshold
// - almost full low at space <= threshold
// - master clear empties, flags empty, not full
// - output drive pin enables the data outputs
// - thresholds default to seven after clear
// - empty flags change only on read edges
// - full flags change only on write edges
// - first word readable cycle after not-empty
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module sfp_fifo_top #(
  parameter int DEPTH = sfp_pkg::DEPTH_DEF,
  parameter int DW = sfp_pkg::DATA_W
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic WR_CLK_I,
  input wire logic RD_CLK_I,
  input wire logic [DW-1:0] DATA_I,
  input wire logic WRITE_GATE_A_N_I,
  input wire logic WRITE_GATE_B_OR_LOAD_I,
  input wire logic READ_GATE_A_N_I,
  input wire logic READ_GATE_B_N_I,
  input wire logic MASTER_CLEAR_N_I,
  input wire logic OUTPUT_DRIVE_N_I,
  output logic [DW-1:0] DATA_O,
  output logic DATA_OE_O,
  output logic EMPTY_FLAG_N_O,
  output logic FULL_FLAG_N_O,
  output logic ALMOST_EMPTY_N_O,
  output logic ALMOST_FULL_N_O,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O
);
  import sfp_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam int PV = PIN_DATA + DW;

  typedef struct packed {
    logic [PV-1:0] pin_prev;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW-1:0] wg_r1;
    logic [PW-1:0] wg_r2;
    logic [PW-1:0] rg_w1;
    logic [PW-1:0] rg_w2;
    logic empty_n;
    logic full_n;
    logic ae_n;
    logic af_n;
    logic [AW-1:0] ae_ofs;
    logic [AW-1:0] af_ofs;
    logic ofs_sel;
    sfp_mode_e mode;
    logic [DW-1:0] dout;
  } sfp_state_s;

  sfp_state_s s_r;
  sfp_state_s s_nxt;
  logic [DW-1:0] mem [DEPTH];
  logic [PV-1:0] pin_q;
  logic [PV-1:0] p;
  logic [DW-1:0] din;
  logic soft_clr;
  logic wedge;
  logic redge;
  logic clr;
  logic ld_act;
  logic rd_gate;
  logic wr_ok;
  logic rd_ok;
  logic wr_ofs;
  logic rd_ofs;
  logic [PW-1:0] wptr_n;
  logic [PW-1:0] rptr_n;
  logic [PW-1:0] wcnt;
  logic [PW-1:0] rcnt;
  logic [31:0] stat;
  logic [31:0] thr;

  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = g;
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // every pin, clocks included, passes two flops first
  sfp_pin_sync #(
    .W(PV)
  ) u_sync (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .d_i({DATA_I, OUTPUT_DRIVE_N_I, MASTER_CLEAR_N_I, READ_GATE_B_N_I,
          READ_GATE_A_N_I, WRITE_GATE_B_OR_LOAD_I, WRITE_GATE_A_N_I,
          RD_CLK_I, WR_CLK_I}),
    .q_o(pin_q)
  );

  // register bus
  sfp_apb_regs u_apb (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .psel_i(PSEL_I),
    .penable_i(PENABLE_I),
    .pwrite_i(PWRITE_I),
    .paddr_i(PADDR_I),
    .pwdata_i(PWDATA_I),
    .stat_i(stat),
    .thr_i(thr),
    .prdata_o(PRDATA_O),
    .pready_o(PREADY_O),
    .pslverr_o(PSLVERR_O),
    .soft_clr_o(soft_clr)
  );

  // status and threshold views for software
  always_comb begin
    stat = '0;
    stat[STAT_FULL_BIT] = s_r.full_n;
    stat[STAT_EMPTY_BIT] = s_r.empty_n;
    stat[STAT_AF_BIT] = s_r.af_n;
    stat[STAT_AE_BIT] = s_r.ae_n;
    stat[STAT_MODE_BIT] = (s_r.mode == SFP_LOAD);
    thr = '0;
    thr[THR_AE_LSB +: AW] = s_r.ae_ofs;
    thr[THR_AF_LSB +: AW] = s_r.af_ofs;
  end

  //////////////////////////////////////////////////////////////////////
  // next state; enables and data come from the sample before the edge
  always_comb begin
    s_nxt = s_r;
    p = s_r.pin_prev;
    din = p[PIN_DATA +: DW];
    s_nxt.pin_prev = pin_q;
    wedge = pin_q[PIN_WCLK] & ~p[PIN_WCLK];
    redge = pin_q[PIN_RCLK] & ~p[PIN_RCLK];
    clr = ~pin_q[PIN_MCLR_N] | soft_clr;
    ld_act = (s_r.mode == SFP_LOAD) & ~p[PIN_WGB];
    rd_gate = ~p[PIN_RGA] & ~p[PIN_RGB];
    // data write: gate b counts only in two-enable mode
    wr_ok = wedge & ~p[PIN_WGA] & ~ld_act & s_r.full_n &
            ((s_r.mode == SFP_LOAD) | p[PIN_WGB]);
    rd_ok = redge & rd_gate & ~ld_act & s_r.empty_n;
    wr_ofs = wedge & ld_act & ~p[PIN_WGA];
    rd_ofs = redge & ld_act & rd_gate;
    wptr_n = s_r.wptr + PW'(wr_ok);
    rptr_n = s_r.rptr + PW'(rd_ok);
    wcnt = wptr_n - gray2bin(s_r.rg_w2);
    rcnt = gray2bin(s_r.wg_r2) - rptr_n;
    // write side flags and gray pipeline, on write edges only
    if (wedge) begin
      s_nxt.wptr = wptr_n;
      s_nxt.rg_w1 = bin2gray(s_r.rptr);
      s_nxt.rg_w2 = s_r.rg_w1;
      s_nxt.full_n = (wcnt != PW'(DEPTH));
      s_nxt.af_n = ((PW'(DEPTH) - wcnt) > {1'b0, s_r.af_ofs});
    end
    // read side flags and gray pipeline, on read edges only
    if (redge) begin
      s_nxt.rptr = rptr_n;
      s_nxt.wg_r1 = bin2gray(s_r.wptr);
      s_nxt.wg_r2 = s_r.wg_r1;
      s_nxt.empty_n = (rcnt != '0);
      s_nxt.ae_n = (rcnt > {1'b0, s_r.ae_ofs});
    end
    if (rd_ok) begin
      s_nxt.dout = mem[s_r.rptr[AW-1:0]];
    end
    // threshold access alternates almost-empty then almost-full
    if (wr_ofs) begin
      if (s_r.ofs_sel) begin
        s_nxt.af_ofs = din[AW-1:0];
      end else begin
        s_nxt.ae_ofs = din[AW-1:0];
      end
    end
    if (rd_ofs) begin
      s_nxt.dout = DW'(s_r.ofs_sel ? s_r.af_ofs : s_r.ae_ofs);
    end
    if (wr_ofs | rd_ofs) begin
      s_nxt.ofs_sel = ~s_r.ofs_sel;
    end
    // master clear: empty, defaults, and pin strap
    if (clr) begin
      s_nxt.wptr = '0;
      s_nxt.rptr = '0;
      s_nxt.wg_r1 = '0;
      s_nxt.wg_r2 = '0;
      s_nxt.rg_w1 = '0;
      s_nxt.rg_w2 = '0;
      s_nxt.empty_n = 1'b0;
      s_nxt.full_n = 1'b1;
      s_nxt.ae_n = 1'b0;
      s_nxt.af_n = 1'b1;
      s_nxt.ae_ofs = AW'(OFS_DEF);
      s_nxt.af_ofs = AW'(OFS_DEF);
      s_nxt.ofs_sel = 1'b0;
      s_nxt.dout = '0;
      s_nxt.mode = pin_q[PIN_WGB] ? SFP_TWO_EN : SFP_LOAD;
    end
  end

  // state registers
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      s_r <= '0;
      s_r.full_n <= 1'b1;
      s_r.af_n <= 1'b1;
      s_r.ae_ofs <= AW'(OFS_DEF);
      s_r.af_ofs <= AW'(OFS_DEF);
    end else if (CE_I) begin
      s_r <= s_nxt;
    end
  end

  // storage array, written only by an accepted data write
  always_ff @(posedge CORE_CLK_I) begin
    if (CE_I && wr_ok && !clr && !RST_I) begin
      mem[s_r.wptr[AW-1:0]] <= din;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs
  assign DATA_O = s_r.dout;
  assign DATA_OE_O = ~pin_q[PIN_OE_N];
  assign EMPTY_FLAG_N_O = s_r.empty_n;
  assign FULL_FLAG_N_O = s_r.full_n;
  assign ALMOST_EMPTY_N_O = s_r.ae_n;
  assign ALMOST_FULL_N_O = s_r.af_n;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  full_ignore_a: assert property (
    CE_I && wedge && !s_r.full_n && !clr |=> s_r.wptr == $past(s_r.wptr))
    else $error("write accepted while full");
  empty_ignore_a: assert property (
    CE_I && redge && !s_r.empty_n && !clr && !rd_ofs |=>
      s_r.rptr == $past(s_r.rptr) && $stable(DATA_O))
    else $error("read accepted while empty");
  two_en_write_a: assert property (
    CE_I && wedge && !clr && s_r.mode == SFP_TWO_EN && !p[PIN_WGA] &&
      p[PIN_WGB] && s_r.full_n |=> s_r.wptr == PW'($past(s_r.wptr) + 1'b1))
    else $error("two-enable write not taken");
  clear_empty_a: assert property (
    CE_I && clr |=> !EMPTY_FLAG_N_O && FULL_FLAG_N_O && !ALMOST_EMPTY_N_O &&
      s_r.wptr == '0 && s_r.rptr == '0)
    else $error("master clear did not empty");
  clear_ofs_a: assert property (
    CE_I && clr |=> s_r.ae_ofs == AW'(OFS_DEF) && s_r.af_ofs == AW'(OFS_DEF))
    else $error("thresholds not at default");
  strap_mode_a: assert property (
    CE_I && clr |=>
      s_r.mode == ($past(pin_q[PIN_WGB]) ? SFP_TWO_EN : SFP_LOAD))
    else $error("mode strap not caught");
  read_side_a: assert property (
    CE_I && !redge && !clr |=> $stable(EMPTY_FLAG_N_O) &&
      $stable(ALMOST_EMPTY_N_O))
    else $error("empty flags moved off a read edge");
  write_side_a: assert property (
    CE_I && !wedge && !clr |=> $stable(FULL_FLAG_N_O) &&
      $stable(ALMOST_FULL_N_O))
    else $error("full flags moved off a write edge");
  out_drive_a: assert property (
    CE_I ##1 CE_I ##1 1'b1 |-> DATA_OE_O == !$past(OUTPUT_DRIVE_N_I, 2))
    else $error("output enable does not follow pin");
endmodule

// [core/sfp_pkg.sv]
// shared constants and types for the nine-bit flagged fifo
package sfp_pkg;
  localparam int DATA_W = 9;
  localparam int DEPTH_DEF = 64;
  localparam int OFS_DEF = 7;
  // positions inside the synchronised pin vector
  localparam int PIN_WCLK = 0;
  localparam int PIN_RCLK = 1;
  localparam int PIN_WGA = 2;
  localparam int PIN_WGB = 3;
  localparam int PIN_RGA = 4;
  localparam int PIN_RGB = 5;
  localparam int PIN_MCLR_N = 6;
  localparam int PIN_OE_N = 7;
  localparam int PIN_DATA = 8;
  // register map
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_THR = 12'h008;
  localparam int CTRL_CLR_BIT = 0;
  localparam int STAT_FULL_BIT = 0;
  localparam int STAT_EMPTY_BIT = 1;
  localparam int STAT_AF_BIT = 2;
  localparam int STAT_AE_BIT = 3;
  localparam int STAT_MODE_BIT = 4;
  localparam int THR_AE_LSB = 0;
  localparam int THR_AF_LSB = 16;
  localparam logic [31:0] PRDATA_RST = 32'h0000_0000;
  typedef enum logic {SFP_TWO_EN, SFP_LOAD} sfp_mode_e;
endpackage

// [core/sfp_pin_sync.sv]
// two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ns
module sfp_pin_sync #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sfp_sync_s;
  sfp_sync_s s_r;
  sfp_sync_s s_nxt;

  // first stage feeds only the second
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = d_i;
    s_nxt.s2 = s_r.s1;
  end

  // registers, frozen while the enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign q_o = s_r.s2;
endmodule

// [core/sfp_apb_regs.sv]
// apb slave: soft clear control, flag status and thresholds
`timescale 1ns/1ns
module sfp_apb_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] stat_i,
  input wire logic [31:0] thr_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic soft_clr_o
);
  import sfp_pkg::*;
  typedef struct packed {
    logic [31:0] prdata;
    logic slverr;
    logic clr;
  } sfp_apb_s;
  sfp_apb_s s_r;
  sfp_apb_s s_nxt;
  logic setup;
  logic access;
  logic mapped;

  // answer prepared in setup, used in a zero-wait access phase
  always_comb begin
    s_nxt = s_r;
    setup = psel_i & ~penable_i;
    access = psel_i & penable_i;
    mapped = (paddr_i == ADDR_CTRL) | (paddr_i == ADDR_STAT) |
             (paddr_i == ADDR_THR);
    s_nxt.clr = 1'b0;
    if (setup) begin
      s_nxt.slverr = ~mapped;
      s_nxt.prdata = PRDATA_RST;
      if (!pwrite_i && paddr_i == ADDR_STAT) begin
        s_nxt.prdata = stat_i;
      end
      if (!pwrite_i && paddr_i == ADDR_THR) begin
        s_nxt.prdata = thr_i;
      end
    end
    // write takes effect at the completing edge only
    if (access && pwrite_i && paddr_i == ADDR_CTRL) begin
      s_nxt.clr = pwdata_i[CTRL_CLR_BIT];
    end
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign prdata_o = s_r.prdata;
  assign pslverr_o = s_r.slverr & psel_i & penable_i;
  assign pready_o = 1'b1;
  assign soft_clr_o = s_r.clr;
endmodule

// [test/sfp_far_side.sv]
// producer and consumer model on the fifo pin side
`timescale 1ns/1ns
module sfp_far_side (
  input wire logic clk_i,
  input wire logic empty_n_i,
  output logic wr_clk_o,
  output logic rd_clk_o,
  output logic [8:0] data_o,
  output logic wga_n_o,
  output logic wgb_o,
  output logic [1:0] rg_n_o,
  output logic rd_done_o
);
  logic [3:0] wcnt = 4'h0;
  logic [3:0] rcnt = 4'h0;
  logic strap = 1'b1;
  logic ok;

  // idle levels at time zero
  initial begin
    wr_clk_o = 1'b0;
    rd_clk_o = 1'b0;
    data_o = 9'h1FF;
    wga_n_o = 1'b1;
    wgb_o = 1'b1;
    rg_n_o = 2'b11;
    rd_done_o = 1'b0;
  end

  // free-running clocks: write 4 high 4 low, read 5 high 5 low
  always @(posedge clk_i) begin
    wcnt <= (wcnt == 4'h7) ? 4'h0 : wcnt + 4'h1;
    rcnt <= (rcnt == 4'h9) ? 4'h0 : rcnt + 4'h1;
    wr_clk_o <= (wcnt < 4'h4);
    rd_clk_o <= (rcnt < 4'h5);
  end

  // one word per write edge; gates stay active for back-to-back words
  task automatic put(input logic [8:0] d, input logic b);
    if (wga_n_o) begin
      @(negedge wr_clk_o);
      @(posedge clk_i);
    end
    data_o <= d;
    wga_n_o <= 1'b0;
    wgb_o <= b;
    @(posedge wr_clk_o);
    repeat (5) @(posedge clk_i);
  endtask

  // release the write side; data lines stop showing the last word
  task automatic wr_end();
    data_o <= ~data_o;
    wga_n_o <= 1'b1;
    wgb_o <= strap;
  endtask

  // level of the dual-purpose pin while idle and during clear
  task automatic set_strap(input logic b);
    strap = b;
    wgb_o <= b;
  endtask

  // one read period; reports a read only when the device should make one
  task automatic get(input logic [1:0] pat, input logic b,
      input logic thr);
    @(negedge rd_clk_o);
    @(posedge clk_i);
    rg_n_o <= pat;
    wgb_o <= b;
    @(posedge rd_clk_o);
    ok = (pat == 2'b00) && (thr || empty_n_i);
    repeat (4) @(posedge clk_i);
    rd_done_o <= ok;
    @(posedge clk_i);
    rd_done_o <= 1'b0;
    @(posedge clk_i);
    rg_n_o <= 2'b11;
    wgb_o <= strap;
  endtask
endmodule

// [test/sfp_fifo_top_bench.sv]
// self-checking bench for the nine-bit flagged fifo
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sfp_fifo_top_bench;
  import sfp_pkg::*;
  localparam int DEP = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mclr_n = 1'b0;
  logic oe_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic wclk, rclk, wga_n, wgb, rdone;
  logic [1:0] rg_n;
  logic [8:0] din, w;
  logic [8:0] exp_w;
  logic [8:0] tv [3] = '{9'h003, 9'h00C, 9'h003};
  logic [8:0] dq [$];
  logic [32:0] aq [$];
  integer seed = 32'h442776fa;
  int n_errors = 0;
  int compares = 0;
  wire [8:0] DATA_O;
  wire DATA_OE_O, EMPTY_FLAG_N_O, FULL_FLAG_N_O;
  wire ALMOST_EMPTY_N_O, ALMOST_FULL_N_O, PREADY_O, PSLVERR_O;
  wire [31:0] PRDATA_O;

  always #2 clk = ~clk;

  sfp_fifo_top #(.DEPTH(DEP)) DUT (
    .CORE_CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
    .WR_CLK_I(wclk), .RD_CLK_I(rclk), .DATA_I(din),
    .WRITE_GATE_A_N_I(wga_n), .WRITE_GATE_B_OR_LOAD_I(wgb),
    .READ_GATE_A_N_I(rg_n[0]), .READ_GATE_B_N_I(rg_n[1]),
    .MASTER_CLEAR_N_I(mclr_n), .OUTPUT_DRIVE_N_I(oe_n),
    .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O),
    .EMPTY_FLAG_N_O(EMPTY_FLAG_N_O), .FULL_FLAG_N_O(FULL_FLAG_N_O),
    .ALMOST_EMPTY_N_O(ALMOST_EMPTY_N_O), .ALMOST_FULL_N_O(ALMOST_FULL_N_O),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr),
    .PWDATA_I(pwd), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O));

  sfp_far_side far (
    .clk_i(clk), .empty_n_i(EMPTY_FLAG_N_O), .wr_clk_o(wclk),
    .rd_clk_o(rclk), .data_o(din), .wga_n_o(wga_n), .wgb_o(wgb),
    .rg_n_o(rg_n), .rd_done_o(rdone));

  // oldest noted word against each word the consumer took
  always @(posedge clk) begin
    if (rdone) begin
      `CHK(dq.size() > 0, 1'b1)
      exp_w = dq.pop_front();
      `CHK(DATA_O, exp_w)
    end
  end

  // oldest noted bus answer against each completed access
  always @(posedge clk) begin
    if (psel && pen && PREADY_O === 1'b1) begin
      `CHK(PSLVERR_O, aq[0][32])
      if (!pwr) `CHK(PRDATA_O, aq[0][31:0])
      void'(aq.pop_front());
    end
  end

  // one apb transfer, expected answer noted first
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, input logic [32:0] e);
    aq.push_back(e);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (PREADY_O !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // master clear with the dual pin strapped to b
  task automatic clr(input logic b);
    @(posedge clk);
    far.set_strap(b);
    mclr_n <= 1'b0;
    repeat (6) @(posedge clk);
    mclr_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  task automatic print_verdict();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    clr(1'b1);
    apb(1'b0, ADDR_STAT, 32'h0, {1'b0, 32'h0000_0005});
    apb(1'b1, ADDR_THR, 32'h3F, {1'b0, 32'h0});
    apb(1'b0, ADDR_THR, 32'h0, {1'b0, 32'h0007_0007});
    apb(1'b0, 12'h00C, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h010, 32'h1, {1'b1, 32'h0});
    oe_n <= 1'b1;
    tick(5);
    `CHK(DATA_OE_O, 1'b0)
    @(posedge clk);
    oe_n <= 1'b0;
    tick(5);
    `CHK(DATA_OE_O, 1'b1)
    for (int k = 1; k <= DEP; k++) begin
      w = 9'($random(seed));
      dq.push_back(w);
      far.put(w, 1'b1);
      `CHK(FULL_FLAG_N_O, k < DEP)
      `CHK(ALMOST_FULL_N_O, DEP - k > OFS_DEF)
    end
    far.put(~w, 1'b1);
    far.wr_end();
    tick(60);
    `CHK(ALMOST_EMPTY_N_O, 1'b1)
    `CHK(EMPTY_FLAG_N_O, 1'b1)
    for (int k = 1; k <= DEP; k++) begin
      far.get(2'b00, 1'b1, 1'b0);
      `CHK(ALMOST_EMPTY_N_O, DEP - k > OFS_DEF)
      `CHK(EMPTY_FLAG_N_O, k < DEP)
    end
    w = DATA_O;
    far.get(2'b00, 1'b1, 1'b0);
    `CHK(DATA_O, w)
    far.put(9'h0A5, 1'b0);
    far.wr_end();
    tick(60);
    `CHK(EMPTY_FLAG_N_O, 1'b0)
    far.put(9'h05A, 1'b1);
    far.wr_end();
    tick(60);
    far.get(2'b01, 1'b1, 1'b0);
    far.get(2'b10, 1'b1, 1'b0);
    `CHK(EMPTY_FLAG_N_O, 1'b1)
    dq.push_back(9'h05A);
    far.get(2'b00, 1'b1, 1'b0);
    clr(1'b0);
    apb(1'b0, ADDR_STAT, 32'h0, {1'b0, 32'h0000_0015});
    far.put(9'h003, 1'b0);
    far.put(9'h00C, 1'b0);
    far.wr_end();
    apb(1'b0, ADDR_THR, 32'h0, {1'b0, 32'h000C_0003});
    foreach (tv[i]) begin
      dq.push_back(tv[i]);
      far.get(2'b00, 1'b0, 1'b1);
    end
    for (int k = 0; k < 4; k++) begin
      w = 9'($random(seed));
      dq.push_back(w);
      far.put(w, 1'b1);
    end
    far.wr_end();
    tick(60);
    `CHK(ALMOST_EMPTY_N_O, 1'b1)
    `CHK(ALMOST_FULL_N_O, 1'b0)
    repeat (2) far.get(2'b00, 1'b1, 1'b0);
    dq.delete();
    @(posedge clk);
    far.set_strap(1'b1);
    apb(1'b1, ADDR_CTRL, 32'h1, {1'b0, 32'h0});
    tick(10);
    `CHK(EMPTY_FLAG_N_O, 1'b0)
    apb(1'b0, ADDR_STAT, 32'h0, {1'b0, 32'h0000_0005});
    apb(1'b0, ADDR_THR, 32'h0, {1'b0, 32'h0007_0007});
    tick(4);
    `CHK(aq.size(), 0)
    print_verdict();
  end
endmodule
